// ==== verilog/lgc_map.svh ====
// register indices, field positions, reset values and counts of the line global control block
`ifndef LGC_MAP_SVH
`define LGC_MAP_SVH

// register indices; byte address is four times the index
`define LGC_IDX_CTL_ONE   12'hFE1
`define LGC_IDX_CTL_TWO   12'hFE2
`define LGC_IDX_CTL_THREE 12'hFE4
`define LGC_IDX_CTL_FOUR  12'hFE6
`define LGC_IDX_INT_STAT  12'hFF0
`define LGC_IDX_INT_MASK  12'hFF1

// field positions in the first control register
`define LGC_BIT_TRISTATE  0
`define LGC_BIT_EXTENDED  1
`define LGC_BIT_MUTE      2

// field widths and reset values
`define LGC_W_ONE         3
`define LGC_W_FOUR        5
`define LGC_RST_ONE       3'h0
`define LGC_RST_TWO       8'h00
`define LGC_RST_THREE     8'h00
`define LGC_RST_FOUR      5'h01

// zero-run lengths that declare loss of signal
`define LGC_ZEROS_STD     175
`define LGC_ZEROS_EXT     4096

// master clock rate select codes
`define LGC_SEL_2048_A    4'h0
`define LGC_SEL_1544_A    4'h1
`define LGC_SEL_4096      4'h8
`define LGC_SEL_3088      4'h9
`define LGC_SEL_8192      4'hA
`define LGC_SEL_6176      4'hB
`define LGC_SEL_16384     4'hC
`define LGC_SEL_12352     4'hD
`define LGC_SEL_2048_B    4'hE
`define LGC_SEL_1544_B    4'hF

`endif

// ==== verilog/lgc_pkg.sv ====
// types shared by the line global control block
package lgc_pkg;

	// decoded master clock input rate
	typedef enum logic [2:0] {
		LGC_RATE_2048  = 3'b000,
		LGC_RATE_1544  = 3'b001,
		LGC_RATE_4096  = 3'b010,
		LGC_RATE_3088  = 3'b011,
		LGC_RATE_8192  = 3'b100,
		LGC_RATE_6176  = 3'b101,
		LGC_RATE_16384 = 3'b110,
		LGC_RATE_12352 = 3'b111
	} lgc_rate_type;

	// state of the rate decoder
	typedef struct packed {
		lgc_rate_type rate;
		logic         valid;
	} lgc_rate_state_type;

endpackage : lgc_pkg

// ==== verilog/lgc_los_if.sv ====
// per-channel link between the control block and its zero-run detector
`timescale 1ns/100ps
interface lgc_los_if;
	logic bit_strobe;
	logic bit_data;
	logic extended;
	logic los;

	modport det (input bit_strobe, input bit_data, input extended, output los);
	modport ctl (output bit_strobe, output bit_data, output extended, input los);
endinterface : lgc_los_if

// ==== verilog/lgc_los_det.sv ====
// zero-run loss of signal detector for one receive channel
`timescale 1ns/100ps
`include "lgc_map.svh"
module lgc_los_det #(
	parameter int ZEROS_STD = `LGC_ZEROS_STD,
	parameter int ZEROS_EXT = `LGC_ZEROS_EXT
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// channel link
	lgc_los_if.det    lk
);
	localparam int CW = $clog2(ZEROS_EXT + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          los;
	} lgc_det_state_type;

	lgc_det_state_type s_q;
	lgc_det_state_type s_d;
	logic [CW-1:0]     thr_w;

	// threshold follows the extended control at once
	assign thr_w = lk.extended ? CW'(ZEROS_EXT) : CW'(ZEROS_STD);

	// count zeros per bit, a one ends the run and clears the loss
	always_comb
	begin
		s_d = s_q;
		if (lk.bit_strobe)
		begin
			if (lk.bit_data)
			begin
				s_d.cnt = '0;
				s_d.los = 1'b0;
			end
			else if (s_q.cnt < thr_w)
			begin
				s_d.cnt = s_q.cnt + CW'(1);
				if (s_q.cnt + CW'(1) >= thr_w)
					s_d.los = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign lk.los = s_q.los;

	// loss declared only on the bit that completes the run
	property p_ext_run;
		@(posedge clk_i) disable iff (!reset_n_i)
		($rose(s_q.los) && $past(lk.extended)) |->
			($past(s_q.cnt) == CW'(ZEROS_EXT - 1)) && $past(lk.bit_strobe && !lk.bit_data);
	endproperty
	a_ext_run : assert property (p_ext_run) else $error("extended loss not after full run");

	property p_std_run;
		@(posedge clk_i) disable iff (!reset_n_i)
		($rose(s_q.los) && !$past(lk.extended)) |->
			($past(s_q.cnt) == CW'(ZEROS_STD - 1)) && $past(lk.bit_strobe && !lk.bit_data);
	endproperty
	a_std_run : assert property (p_std_run) else $error("standard loss not after full run");

endmodule : lgc_los_det

// ==== verilog/lgc_rate_dec.sv ====
// master clock rate decoder with registered result
`timescale 1ns/100ps
`include "lgc_map.svh"
module lgc_rate_dec (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	// select code in, decoded rate out
	input  wire logic [3:0]           sel_i,
	output lgc_pkg::lgc_rate_type     rate_o,
	output logic                      valid_o
);
	lgc_pkg::lgc_rate_state_type s_q;
	lgc_pkg::lgc_rate_state_type s_d;

	// reserved codes keep the last rate but drop valid
	always_comb
	begin
		s_d = s_q;
		s_d.valid = 1'b1;
		case (sel_i)
			`LGC_SEL_2048_A, `LGC_SEL_2048_B : s_d.rate = lgc_pkg::LGC_RATE_2048;
			`LGC_SEL_1544_A, `LGC_SEL_1544_B : s_d.rate = lgc_pkg::LGC_RATE_1544;
			`LGC_SEL_4096  : s_d.rate = lgc_pkg::LGC_RATE_4096;
			`LGC_SEL_3088  : s_d.rate = lgc_pkg::LGC_RATE_3088;
			`LGC_SEL_8192  : s_d.rate = lgc_pkg::LGC_RATE_8192;
			`LGC_SEL_6176  : s_d.rate = lgc_pkg::LGC_RATE_6176;
			`LGC_SEL_16384 : s_d.rate = lgc_pkg::LGC_RATE_16384;
			`LGC_SEL_12352 : s_d.rate = lgc_pkg::LGC_RATE_12352;
			default        : s_d.valid = 1'b0;
		endcase
	end

	// reset matches the select field reset code
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s_q <= '{rate: lgc_pkg::LGC_RATE_1544, valid: 1'b1};
		else
			s_q <= s_d;
	end

	assign rate_o  = s_q.rate;
	assign valid_o = s_q.valid;

	property p_dup_codes;
		@(posedge clk_i) disable iff (!reset_n_i)
		(sel_i == `LGC_SEL_2048_B || sel_i == `LGC_SEL_1544_B) |=>
			valid_o && (rate_o == ($past(sel_i) == `LGC_SEL_2048_B ? lgc_pkg::LGC_RATE_2048
			                                                        : lgc_pkg::LGC_RATE_1544));
	endproperty
	a_dup_codes : assert property (p_dup_codes) else $error("duplicate rate code misdecoded");

	property p_reserved;
		@(posedge clk_i) disable iff (!reset_n_i)
		(sel_i[3] == 1'b0 && sel_i[2:1] != 2'b00) |=> !valid_o && $stable(rate_o);
	endproperty
	a_reserved : assert property (p_reserved) else $error("reserved rate code accepted");

endmodule : lgc_rate_dec

// ==== verilog/lgc_top.sv ====
// line interface global control registers with per-channel mute and loss detection
`timescale 1ns/100ps
`include "lgc_map.svh"
module lgc_top #(
	parameter int CHANNELS  = 8,
	parameter int ZEROS_STD = `LGC_ZEROS_STD,
	parameter int ZEROS_EXT = `LGC_ZEROS_EXT
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	// apb slave
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [15:0]         paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	// receive line side, one bit per channel
	input  wire logic [CHANNELS-1:0] rx_bit_strobe_i,
	input  wire logic [CHANNELS-1:0] rx_data_i,
	input  wire logic [CHANNELS-1:0] rx_clk_i,
	// towards the framer
	output logic      [CHANNELS-1:0] rx_data_o,
	output logic      [CHANNELS-1:0] rx_clk_o,
	output logic      [CHANNELS-1:0] receive_signal_loss_o,
	// pin drive enables, low in test tristate
	output logic      [CHANNELS-1:0] chan_out_oe_o,
	// master clock input rate
	output lgc_pkg::lgc_rate_type    master_clock_rate_o,
	output logic                     master_clock_rate_valid_o,
	// interrupt
	output logic                     irq_o
);
	typedef struct packed {
		logic [`LGC_W_ONE-1:0]  ctl_one;
		logic [7:0]             ctl_two;
		logic [7:0]             ctl_three;
		logic [`LGC_W_FOUR-1:0] ctl_four;
		logic [CHANNELS-1:0]    stat;
		logic [CHANNELS-1:0]    mask;
		logic [CHANNELS-1:0]    los_prev;
		logic [CHANNELS-1:0]    rx_data;
		logic [CHANNELS-1:0]    rx_clk;
		logic [CHANNELS-1:0]    oe;
		logic [31:0]            rdata;
	} lgc_top_state_type;

	localparam lgc_top_state_type RST_VAL = '{
		ctl_one:   `LGC_RST_ONE,
		ctl_two:   `LGC_RST_TWO,
		ctl_three: `LGC_RST_THREE,
		ctl_four:  `LGC_RST_FOUR,
		oe:        '1,
		default:   '0
	};

	lgc_top_state_type   s_q;
	lgc_top_state_type   s_d;
	logic [CHANNELS-1:0] los_w;
	logic                mute_w;
	logic                ext_w;
	logic                tri_w;
	logic                word_ok_w;
	logic                hit_one;
	logic                hit_two;
	logic                hit_three;
	logic                hit_four;
	logic                hit_stat;
	logic                hit_mask;
	logic                mapped_w;
	logic                access_w;
	logic                wr_w;
	logic [31:0]         rd_mux_w;

	// control fields
	assign mute_w = s_q.ctl_one[`LGC_BIT_MUTE];
	assign ext_w  = s_q.ctl_one[`LGC_BIT_EXTENDED];
	assign tri_w  = s_q.ctl_one[`LGC_BIT_TRISTATE];

	// one zero-run detector per channel
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_chan
			lgc_los_if lk ();
			assign lk.bit_strobe = rx_bit_strobe_i[g];
			assign lk.bit_data   = rx_data_i[g];
			assign lk.extended   = ext_w;
			assign los_w[g]      = lk.los;
			lgc_los_det #(
				.ZEROS_STD (ZEROS_STD),
				.ZEROS_EXT (ZEROS_EXT)
			) u_det (
				.clk_i     (clk_i),
				.reset_n_i (reset_n_i),
				.lk        (lk.det)
			);
		end
	endgenerate

	// rate decode of the select field
	lgc_rate_dec u_rate (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.sel_i     (s_q.ctl_four[3:0]),
		.rate_o    (master_clock_rate_o),
		.valid_o   (master_clock_rate_valid_o)
	);

	// word decode; offsets are indices, so byte address is index times four
	assign word_ok_w = (paddr_i[15:14] == 2'h0) && (paddr_i[1:0] == 2'h0);
	assign hit_one   = word_ok_w && (paddr_i[13:2] == `LGC_IDX_CTL_ONE);
	assign hit_two   = word_ok_w && (paddr_i[13:2] == `LGC_IDX_CTL_TWO);
	assign hit_three = word_ok_w && (paddr_i[13:2] == `LGC_IDX_CTL_THREE);
	assign hit_four  = word_ok_w && (paddr_i[13:2] == `LGC_IDX_CTL_FOUR);
	assign hit_stat  = word_ok_w && (paddr_i[13:2] == `LGC_IDX_INT_STAT);
	assign hit_mask  = word_ok_w && (paddr_i[13:2] == `LGC_IDX_INT_MASK);
	assign mapped_w  = hit_one | hit_two | hit_three | hit_four | hit_stat | hit_mask;

	// zero wait states: read data is latched in setup, so access can end at once
	assign access_w  = psel_i && penable_i;
	assign wr_w      = access_w && pwrite_i && mapped_w;
	assign pready_o  = access_w;
	assign pslverr_o = access_w && !mapped_w;
	assign prdata_o  = s_q.rdata;

	// read mux, unused bits and unmapped words read zero
	always_comb
	begin
		rd_mux_w = '0;
		if (hit_one)
			rd_mux_w = 32'(s_q.ctl_one);
		else if (hit_two)
			rd_mux_w = 32'(s_q.ctl_two);
		else if (hit_three)
			rd_mux_w = 32'(s_q.ctl_three);
		else if (hit_four)
			rd_mux_w = 32'(s_q.ctl_four);
		else if (hit_stat)
			rd_mux_w = 32'(s_q.stat);
		else if (hit_mask)
			rd_mux_w = 32'(s_q.mask);
	end

	// next state: registers, sticky status, line outputs
	always_comb
	begin
		s_d = s_q;
		if (psel_i && !penable_i)
			s_d.rdata = rd_mux_w;
		if (wr_w && hit_one)
			s_d.ctl_one = pwdata_i[`LGC_W_ONE-1:0];
		if (wr_w && hit_two)
			s_d.ctl_two = pwdata_i[7:0];
		if (wr_w && hit_three)
			s_d.ctl_three = pwdata_i[7:0];
		if (wr_w && hit_four)
			s_d.ctl_four = pwdata_i[`LGC_W_FOUR-1:0];
		if (wr_w && hit_mask)
			s_d.mask = pwdata_i[CHANNELS-1:0];
		// write one clears, a new loss in the same cycle wins
		if (wr_w && hit_stat)
			s_d.stat = s_q.stat & ~pwdata_i[CHANNELS-1:0];
		s_d.stat     = s_d.stat | (los_w & ~s_q.los_prev);
		s_d.los_prev = los_w;
		// muted data forced low, clock always passes
		s_d.rx_data  = mute_w ? (rx_data_i & ~los_w) : rx_data_i;
		s_d.rx_clk   = rx_clk_i;
		s_d.oe       = tri_w ? '0 : '1;
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s_q <= RST_VAL;
		else
			s_q <= s_d;
	end

	// outputs straight from flip-flops, except irq, the OR of status flops gated by mask flops
	assign rx_data_o             = s_q.rx_data;
	assign rx_clk_o              = s_q.rx_clk;
	assign chan_out_oe_o         = s_q.oe;
	assign receive_signal_loss_o = los_w;
	assign irq_o                 = |(s_q.stat & s_q.mask);

	// a write to a control register as a named step
	sequence s_wr_two;
		wr_w && hit_two;
	endsequence

	sequence s_wr_three;
		wr_w && hit_three;
	endsequence

	property p_mute_low;
		@(posedge clk_i) disable iff (!reset_n_i)
		mute_w |=> ((rx_data_o & $past(los_w)) == '0);
	endproperty
	a_mute_low : assert property (p_mute_low) else $error("muted data not low during loss");

	property p_mute_pass;
		@(posedge clk_i) disable iff (!reset_n_i)
		!mute_w |=> (rx_data_o == $past(rx_data_i));
	endproperty
	a_mute_pass : assert property (p_mute_pass) else $error("unmuted data altered");

	property p_clk_runs;
		@(posedge clk_i) disable iff (!reset_n_i)
		(mute_w && (los_w != '0)) |=> (rx_clk_o == $past(rx_clk_i));
	endproperty
	a_clk_runs : assert property (p_clk_runs) else $error("receive clock muted");

	property p_tristate;
		@(posedge clk_i) disable iff (!reset_n_i)
		tri_w |=> (chan_out_oe_o == '0);
	endproperty
	a_tristate : assert property (p_tristate) else $error("outputs driven in test tristate");

	property p_release;
		@(posedge clk_i) disable iff (!reset_n_i)
		$fell(tri_w) |=> (chan_out_oe_o == '1);
	endproperty
	a_release : assert property (p_release) else $error("outputs not restored");

	property p_two_store;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_wr_two |=> (s_q.ctl_two[6:0] == $past(pwdata_i[6:0])) && (master_clock_rate_o == $past(master_clock_rate_o));
	endproperty
	a_two_store : assert property (p_two_store) else $error("second register not stored");

	property p_three_store;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_wr_three |=> (s_q.ctl_three == $past(pwdata_i[7:0])) ##1 (s_q.ctl_three == $past(s_q.ctl_three) || wr_w);
	endproperty
	a_three_store : assert property (p_three_store) else $error("third register not stored");

	// the decoder registers once, so the code shows up one edge later
	property p_rate_reset;
		@(posedge clk_i) disable iff (!reset_n_i)
		(s_q.ctl_four[3:0] == `LGC_SEL_1544_A) |=>
			(master_clock_rate_o == lgc_pkg::LGC_RATE_1544) && master_clock_rate_valid_o;
	endproperty
	a_rate_reset : assert property (p_rate_reset) else $error("rate code 0001 misdecoded");

	// a refused write as a named step
	sequence s_bad_wr;
		access_w && pwrite_i && !mapped_w;
	endsequence

	// refused writes leave every control register as it was
	property p_bad_wr_kept;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_bad_wr |=> $stable(s_q.ctl_one) && $stable(s_q.ctl_two) && $stable(s_q.ctl_three) && $stable(s_q.ctl_four);
	endproperty
	a_bad_wr_kept : assert property (p_bad_wr_kept) else $error("refused write changed a register");

	// a fresh loss lands in status even when software clears in the same cycle
	property p_stat_set;
		@(posedge clk_i) disable iff (!reset_n_i)
		((los_w & ~s_q.los_prev) != '0) |=>
			((s_q.stat & $past(los_w & ~s_q.los_prev)) == $past(los_w & ~s_q.los_prev));
	endproperty
	a_stat_set : assert property (p_stat_set) else $error("loss event lost from status");

	// sticky: status bits only fall through a write of ones
	property p_stat_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		!(wr_w && hit_stat) |=> ((s_q.stat & $past(s_q.stat)) == $past(s_q.stat));
	endproperty
	a_stat_hold : assert property (p_stat_hold) else $error("status bit dropped without a clear");

	// a masked-in loss raises the interrupt on the edge that sets status
	property p_irq_raise;
		@(posedge clk_i) disable iff (!reset_n_i)
		(((s_q.mask & los_w & ~s_q.los_prev) != '0) && !(wr_w && hit_mask)) |=> irq_o;
	endproperty
	a_irq_raise : assert property (p_irq_raise) else $error("interrupt missed a masked-in loss");

endmodule : lgc_top

// ==== testbench/lgc_line_model.sv ====
// behavioural receive line: recovered bits, strobes and clock for every channel
`timescale 1ns/100ps
module lgc_line_model #(
	parameter int CH = 2
) (
	// clock and command from the bench
	input  wire logic          clk_i,
	input  wire logic          send_i,
	input  wire logic          bit_i,
	// recovered line towards the block
	output logic      [CH-1:0] strobe_o,
	output logic      [CH-1:0] data_o,
	output logic      [CH-1:0] clk_o
);
	logic idle_q = 1'b0;

	// recovered clock keeps running; between bits the data line wanders so a stale value never looks settled
	// outputs settle on the first edge, well inside the bench reset
	always @(posedge clk_i)
	begin
		clk_o    <= idle_q;
		strobe_o <= {CH{send_i}};
		idle_q   <= ~idle_q;
		data_o   <= send_i ? {CH{bit_i}} : {CH{idle_q}};
	end
endmodule : lgc_line_model

// ==== testbench/line_interface_global_control_tb.sv ====
// self-checking bench for the line global control block
`timescale 1ns/100ps
`include "lgc_map.svh"
module line_interface_global_control_tb;
	localparam int          CH    = 2;
	localparam int          NSTD  = 5;
	localparam int          NEXT  = 16;
	localparam logic [15:0] A_ONE = 16'(`LGC_IDX_CTL_ONE * 4);
	localparam logic [15:0] A_TWO = 16'(`LGC_IDX_CTL_TWO * 4);
	localparam logic [15:0] A_THR = 16'(`LGC_IDX_CTL_THREE * 4);
	localparam logic [15:0] A_FOU = 16'(`LGC_IDX_CTL_FOUR * 4);
	localparam logic [15:0] A_STA = 16'(`LGC_IDX_INT_STAT * 4);
	localparam logic [15:0] A_MSK = 16'(`LGC_IDX_INT_MASK * 4);

	logic                  clk_i     = 1'b0;
	logic                  reset_n_i = 1'b0;
	logic                  psel_i    = 1'b0;
	logic                  penable_i = 1'b0;
	logic                  pwrite_i  = 1'b0;
	logic [15:0]           paddr_i   = '0;
	logic [31:0]           pwdata_i  = '0;
	logic                  send      = 1'b0;
	logic                  bitv      = 1'b0;
	logic [31:0]           prdata_o;
	logic                  pready_o;
	logic                  pslverr_o;
	logic                  valid;
	logic                  irq_o;
	logic [CH-1:0]         stb;
	logic [CH-1:0]         rxd;
	logic [CH-1:0]         rxc;
	logic [CH-1:0]         dout;
	logic [CH-1:0]         cout;
	logic [CH-1:0]         loss;
	logic [CH-1:0]         oe;
	lgc_pkg::lgc_rate_type rate;
	int                    err_total = 0;
	int                    checks    = 0;
	logic [31:0]           rd;
	logic                  er;

	always #5 clk_i = ~clk_i;

	lgc_line_model #(.CH(CH)) line (.clk_i(clk_i), .send_i(send), .bit_i(bitv), .strobe_o(stb), .data_o(rxd),
		.clk_o(rxc));

	lgc_top #(.CHANNELS(CH), .ZEROS_STD(NSTD), .ZEROS_EXT(NEXT)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_bit_strobe_i(stb),
		.rx_data_i(rxd), .rx_clk_i(rxc), .rx_data_o(dout), .rx_clk_o(cout), .receive_signal_loss_o(loss),
		.chan_out_oe_o(oe), .master_clock_rate_o(rate), .master_clock_rate_valid_o(valid), .irq_o(irq_o));

	// one comparison, counted and reported
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// no wait-state count is assumed; only the watchdog ends a hung access
		do
		begin
			@(posedge clk_i);
		end
		while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task rchk(input string name, input logic [15:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(name, exp, rd);
		chk({name, " err"}, 32'h0000_0000, {31'h0, er});
	endtask : rchk

	// strobes n bits of one value, then lets the detector settle
	task send_bits(input int n, input logic b);
		bitv <= b;
		send <= 1'b1;
		repeat (n) @(posedge clk_i);
		send <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : send_bits

	task t_reset();
		chk("rate", 32'h1, {29'h0, rate});
		chk("valid", 32'h1, {31'h0, valid});
		chk("oe", {{(32-CH){1'b0}}, {CH{1'b1}}}, {{(32-CH){1'b0}}, oe});
		rchk("one", A_ONE, 32'h0);
		rchk("two", A_TWO, 32'h0);
		rchk("three", A_THR, 32'h0);
		rchk("four", A_FOU, 32'h1);
		rchk("mask", A_MSK, 32'h0);
	endtask : t_reset

	task t_regs();
		apb(1'b1, A_TWO, 32'h0000_007F);
		rchk("two rw", A_TWO, 32'h7F);
		apb(1'b1, A_THR, 32'hFFFF_FFFF);
		rchk("three rw", A_THR, 32'hFF);
		chk("rate kept", 32'h1, {29'h0, rate});
		apb(1'b0, 16'h0100, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, A_TWO + 16'h1, 32'h0000_0055);
		chk("unaligned err", 32'h1, {31'h0, er});
		rchk("two kept", A_TWO, 32'h7F);
	endtask : t_regs

	task t_rate();
		logic [2:0] last;
		logic [3:0] e;
		last = 3'h1;
		for (int c = 0; c < 16; c++)
		begin
			case (c)
				8: e = {1'b1, 3'h2};
				9: e = {1'b1, 3'h3};
				10: e = {1'b1, 3'h4};
				11: e = {1'b1, 3'h5};
				12: e = {1'b1, 3'h6};
				13: e = {1'b1, 3'h7};
				0, 14: e = {1'b1, 3'h0};
				1, 15: e = {1'b1, 3'h1};
				default: e = {1'b0, last};
			endcase
			last = e[2:0];
			apb(1'b1, A_FOU, 32'(c));
			repeat (3) @(posedge clk_i);
			chk("rate code", {28'h0, e}, {28'h0, valid, rate});
		end
	endtask : t_rate

	task t_los_std();
		apb(1'b1, A_ONE, 32'h0);
		send_bits(NSTD - 1, 1'b0);
		chk("loss short", 32'h0, {{(32-CH){1'b0}}, loss});
		send_bits(1, 1'b0);
		chk("loss std", 32'h3, {{(32-CH){1'b0}}, loss});
		rchk("status", A_STA, 32'h3);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		apb(1'b1, A_MSK, 32'h0000_0003);
		@(negedge clk_i);
		chk("irq on", 32'h1, {31'h0, irq_o});
		apb(1'b1, A_STA, 32'h0000_0003);
		@(negedge clk_i);
		chk("irq clr", 32'h0, {31'h0, irq_o});
		rchk("status clr", A_STA, 32'h0);
		send_bits(1, 1'b1);
		chk("loss gone", 32'h0, {{(32-CH){1'b0}}, loss});
	endtask : t_los_std

	task t_los_ext_mute();
		logic [CH-1:0] pd;
		logic [CH-1:0] pc;
		apb(1'b1, A_ONE, 32'h0000_0002);
		send_bits(NEXT - 1, 1'b0);
		chk("loss ext short", 32'h0, {{(32-CH){1'b0}}, loss});
		send_bits(1, 1'b0);
		chk("loss ext", 32'h3, {{(32-CH){1'b0}}, loss});
		for (int m = 1; m >= 0; m--)
		begin
			apb(1'b1, A_ONE, 32'(2 + 4 * m));
			@(negedge clk_i);
			for (int k = 0; k < 6; k++)
			begin
				pd = rxd;
				pc = rxc;
				@(negedge clk_i);
				chk("data out", {{(32-CH){1'b0}}, m ? {CH{1'b0}} : pd}, {{(32-CH){1'b0}}, dout});
				chk("clk out", {{(32-CH){1'b0}}, pc}, {{(32-CH){1'b0}}, cout});
			end
		end
		send_bits(1, 1'b1);
	endtask : t_los_ext_mute

	task t_tristate();
		apb(1'b1, A_ONE, 32'h0000_0001);
		repeat (3) @(posedge clk_i);
		chk("oe off", 32'h0, {{(32-CH){1'b0}}, oe});
		apb(1'b1, A_ONE, 32'h0000_0000);
		repeat (3) @(posedge clk_i);
		chk("oe on", {{(32-CH){1'b0}}, {CH{1'b1}}}, {{(32-CH){1'b0}}, oe});
	endtask : t_tristate

	task tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// watchdog: the sequence needs well under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(negedge clk_i);
		t_reset();
		t_regs();
		t_rate();
		t_los_std();
		t_los_ext_mute();
		t_tristate();
		tally_and_finish();
	end
endmodule : line_interface_global_control_tb
